// ==== design/rod_defs.svh ====
// opcode fields, function codes and the decoder's contract
// Contract
// - opcode 0x39 sub-field 00001 is the not-equal integer flag compare.
// - under 0x39, 00100 unsigned less-than, 01100 signed less-than flag compares.
// - under 0x39, 00101 unsigned and 01101 signed less-or-equal compares.
// - under 0x39, 00010 unsigned and 01010 signed greater-than compares.
// - opcode 0x38 low bits 00001101 sign-extends a word from A to D.
// - opcode 0x38 low bits 00011101 zero-extends a word from A to D.
// - opcode 0x38 low bits 00011100 sign-extends the low byte of A to D.
// - opcode 0x38 low bits 00111100 zero-extends the low byte of A to D.
// - opcode 0x38 low bits 00001100 sign-extends the low half of A to D.
// - opcode 0x38 function 000001 adds A, B and carry into D.
// - opcode 0x32 function 00101110 is single float unordered flag test.
// - opcode 0x32 functions 00101000 to 00101101 are unordered-or single compares.
`ifndef ROD_DEFS_SVH
`define ROD_DEFS_SVH
`define ROD_OPC_FP 6'h32
`define ROD_OPC_SWA 6'h33
`define ROD_OPC_SW 6'h35
`define ROD_OPC_SB 6'h36
`define ROD_OPC_SH 6'h37
`define ROD_OPC_ALU 6'h38
`define ROD_OPC_SF 6'h39
`define ROD_OPC_CUST5 6'h3c
`define ROD_OPC_CUST8 6'h3f
`define ROD_FN_EXTH 4'hc
`define ROD_FN_EXTW 4'hd
`define ROD_FN_SHIFT 4'h8
`define ROD_FN_FF 4'hf
`define ROD_FN_ADDC 4'h1
`define ROD_FN_CMOV 4'he
`define ROD_FP_CUST_S 4'hd
`define ROD_FP_CUST_D 4'he
`define ROD_FP_UN_S 8'h2e
`define ROD_FP_UEQ_S 8'h28
`define ROD_CUST_IMPL 1'h0
`endif

// ==== design/rod_pkg.sv ====
// types shared by the opcode decoder
package rod_pkg;
    typedef enum logic [3:0] {
        ROD_OP_NONE = 4'h0,
        ROD_OP_FP_ARITH = 4'h1,
        ROD_OP_FP_CMP = 4'h2,
        ROD_OP_FP_CONV = 4'h3,
        ROD_OP_FP_SINGLE_CUSTOM_SLOT = 4'h4,
        ROD_OP_FP_DOUBLE_CUSTOM_SLOT = 4'h5,
        ROD_OP_STORE = 4'h6,
        ROD_OP_ALU = 4'h7,
        ROD_OP_EXT = 4'h8,
        ROD_OP_SHIFT = 4'h9,
        ROD_OP_MULDIV = 4'ha,
        ROD_OP_INT_CMP = 4'hb,
        ROD_OP_CUSTOM = 4'hc
    } rod_class_e;
endpackage

// ==== design/rod_decoder.sv ====
// upper primary-opcode instruction decoder
`timescale 1ns/100ps
`include "rod_defs.svh"
module rod_decoder (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    output logic dec_valid_q,
    output logic [4:0] d_idx_q,
    output logic [4:0] a_idx_q,
    output logic [4:0] b_idx_q,
    output rod_pkg::rod_class_e op_class_q,
    output logic [7:0] op_func_q,
    output logic is_compare_q,
    output logic illegal_q,
    output logic [15:0] store_imm_q
);
    logic [5:0] opc;
    logic [3:0] fn4;
    logic [1:0] hi2;
    logic [7:0] fp_fn;
    logic [4:0] sf_sub;
    logic [4:0] a_fld;
    rod_pkg::rod_class_e class_d;
    logic [7:0] func_d;
    logic cmp_d;
    logic ok_d;

    assign opc = instr[31:26];
    assign fn4 = instr[3:0];
    assign hi2 = instr[9:8];
    assign fp_fn = instr[7:0];
    assign sf_sub = instr[25:21];
    assign a_fld = instr[20:16];

    // primary decode
    always_comb begin
        class_d = rod_pkg::ROD_OP_NONE;
        func_d = 8'h00;
        cmp_d = 1'b0;
        ok_d = 1'b0;
        case (opc)
            `ROD_OPC_FP: begin
                func_d = fp_fn;
                case (fp_fn[7:4])
                    4'h0: begin
                        if (fp_fn[3:0] <= 4'h5 || fp_fn[3:0] == 4'h7) begin
                            ok_d = 1'b1;
                            class_d = (fp_fn[3:0] == 4'h4 || fp_fn[3:0] == 4'h5) ?
                                rod_pkg::ROD_OP_FP_CONV : rod_pkg::ROD_OP_FP_ARITH;
                        end else if (fp_fn[3:0] >= 4'h8 && fp_fn[3:0] <= 4'hd) begin
                            ok_d = 1'b1;
                            cmp_d = 1'b1;
                            class_d = rod_pkg::ROD_OP_FP_CMP;
                        end
                    end
                    4'h1: begin
                        if (fp_fn[3:0] <= 4'h3 || fp_fn[3:0] == 4'h7) begin
                            ok_d = 1'b1;
                            class_d = rod_pkg::ROD_OP_FP_ARITH;
                        end else if (fp_fn[3:0] == 4'h4 || fp_fn[3:0] == 4'h5) begin
                            ok_d = 1'b1;
                            class_d = rod_pkg::ROD_OP_FP_CONV;
                        end else if (fp_fn[3:0] >= 4'h8 && fp_fn[3:0] <= 4'hd) begin
                            ok_d = 1'b1;
                            cmp_d = 1'b1;
                            class_d = rod_pkg::ROD_OP_FP_CMP;
                        end
                    end
                    4'h2, 4'h3: begin
                        // unordered compares, single (0x2_) and double (0x3_), and double conversions 0x34 and 0x35
                        if (fp_fn[3:0] >= 4'h8 && fp_fn[3:0] <= 4'he) begin
                            ok_d = 1'b1;
                            cmp_d = 1'b1;
                            class_d = rod_pkg::ROD_OP_FP_CMP;
                        end else if (fp_fn[7:4] == 4'h3 &&
                                     (fp_fn[3:0] == 4'h4 || fp_fn[3:0] == 4'h5)) begin
                            ok_d = 1'b1;
                            class_d = rod_pkg::ROD_OP_FP_CONV;
                        end
                    end
                    `ROD_FP_CUST_S: begin
                        class_d = rod_pkg::ROD_OP_FP_SINGLE_CUSTOM_SLOT;
                        ok_d = `ROD_CUST_IMPL;
                    end
                    `ROD_FP_CUST_D: begin
                        class_d = rod_pkg::ROD_OP_FP_DOUBLE_CUSTOM_SLOT;
                        ok_d = `ROD_CUST_IMPL;
                    end
                    default: ok_d = 1'b0;
                endcase
            end
            `ROD_OPC_SWA, `ROD_OPC_SW, `ROD_OPC_SB, `ROD_OPC_SH: begin
                ok_d = 1'b1;
                class_d = rod_pkg::ROD_OP_STORE;
                func_d = {2'b00, opc};
            end
            `ROD_OPC_ALU: begin
                func_d = instr[7:0];
                if (fn4 == `ROD_FN_EXTH && hi2 == 2'b00) begin
                    // half sign, byte sign, half zero, byte zero
                    ok_d = (instr[7:6] == 2'b00) && (instr[5:4] <= 2'b11);
                    class_d = rod_pkg::ROD_OP_EXT;
                end else if (fn4 == `ROD_FN_EXTW && hi2 == 2'b00) begin
                    // word sign or word zero
                    ok_d = (instr[7:5] == 3'b000);
                    class_d = rod_pkg::ROD_OP_EXT;
                end else if (hi2 == 2'b00 && (fn4 <= 4'h5 || fn4 == `ROD_FN_CMOV)) begin
                    // add, add with carry, sub, and, or, xor, cmov
                    ok_d = 1'b1;
                    class_d = rod_pkg::ROD_OP_ALU;
                    func_d = {4'h0, fn4};
                end else if (hi2 == 2'b00 && fn4 == `ROD_FN_SHIFT) begin
                    ok_d = 1'b1;
                    class_d = rod_pkg::ROD_OP_SHIFT;
                    func_d = {2'b00, instr[7:6], fn4};
                end else if (fn4 == `ROD_FN_FF && hi2[1] == 1'b0) begin
                    ok_d = 1'b1;
                    class_d = rod_pkg::ROD_OP_ALU;
                    func_d = {2'b00, hi2, fn4};
                end else if (hi2 == 2'b11) begin
                    ok_d = (fn4 == 4'h6) || (fn4 == 4'h7) || (fn4 == 4'h9) ||
                           (fn4 == 4'ha) || (fn4 == 4'hb) || (fn4 == 4'hc);
                    class_d = rod_pkg::ROD_OP_MULDIV;
                    func_d = {4'h0, fn4};
                end
            end
            `ROD_OPC_SF: begin
                func_d = {3'b000, sf_sub};
                cmp_d = 1'b1;
                class_d = rod_pkg::ROD_OP_INT_CMP;
                // 00000-00101 unsigned/equality, 01010-01101 signed
                ok_d = (sf_sub <= 5'h05) || (sf_sub >= 5'h0a && sf_sub <= 5'h0d);
            end
            default: begin
                if (opc >= `ROD_OPC_CUST5 && opc <= `ROD_OPC_CUST8) begin
                    class_d = rod_pkg::ROD_OP_CUSTOM;
                    func_d = {2'b00, opc};
                end
                ok_d = 1'b0;
            end
        endcase
        if (!ok_d) begin
            cmp_d = 1'b0;
        end
    end

    // decoded fields
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            d_idx_q <= 5'h00;
            a_idx_q <= 5'h00;
            b_idx_q <= 5'h00;
            op_class_q <= rod_pkg::ROD_OP_NONE;
            op_func_q <= 8'h00;
            is_compare_q <= 1'b0;
            store_imm_q <= 16'h0000;
        end else begin
            d_idx_q <= instr[25:21];
            a_idx_q <= instr[20:16];
            b_idx_q <= instr[15:11];
            op_class_q <= class_d;
            op_func_q <= func_d;
            is_compare_q <= instr_valid && cmp_d;
            store_imm_q <= {instr[25:21], instr[10:0]};
        end
    end

    // handshake and illegal flag
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            dec_valid_q <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            dec_valid_q <= instr_valid;
            illegal_q <= instr_valid && !ok_d;
        end
    end

    a_sfne_cmp: assert property (@(posedge ref_clk) disable iff (!rst_b)
        instr_valid && instr[31:21] == 11'h721 |=> is_compare_q && !illegal_q &&
            op_class_q == rod_pkg::ROD_OP_INT_CMP && op_func_q == 8'h01)
        else $error("not-equal compare misdecoded");
    a_sflt_cmp: assert property (@(posedge ref_clk) disable iff (!rst_b)
        instr_valid && opc == 6'h39 && (sf_sub == 5'h04 || sf_sub == 5'h0c)
            |=> is_compare_q && op_func_q[4:0] == $past(sf_sub))
        else $error("less-than compare misdecoded");
    a_sfle_cmp: assert property (@(posedge ref_clk) disable iff (!rst_b)
        instr_valid && opc == 6'h39 && (sf_sub == 5'h05 || sf_sub == 5'h0d)
            |=> is_compare_q && !illegal_q)
        else $error("less-equal compare misdecoded");
    a_sfgt_cmp: assert property (@(posedge ref_clk) disable iff (!rst_b)
        instr_valid && opc == 6'h39 && (sf_sub == 5'h02 || sf_sub == 5'h0a)
            |=> is_compare_q && !illegal_q)
        else $error("greater-than compare misdecoded");
    a_ext_word: assert property (@(posedge ref_clk) disable iff (!rst_b)
        instr_valid && opc == 6'h38 && hi2 == 2'b00 &&
            (instr[7:0] == 8'h0d || instr[7:0] == 8'h1d)
            |=> op_class_q == rod_pkg::ROD_OP_EXT && !illegal_q && d_idx_q == $past(sf_sub))
        else $error("word extension misdecoded");
    a_ext_bhalf: assert property (@(posedge ref_clk) disable iff (!rst_b)
        instr_valid && opc == 6'h38 && hi2 == 2'b00 &&
            (instr[7:0] == 8'h1c || instr[7:0] == 8'h3c || instr[7:0] == 8'h0c)
            |=> op_class_q == rod_pkg::ROD_OP_EXT && !illegal_q && a_idx_q == $past(a_fld))
        else $error("byte or half extension misdecoded");
    a_addc_dec: assert property (@(posedge ref_clk) disable iff (!rst_b)
        instr_valid && opc == 6'h38 && instr[9:0] == 10'h001
            |=> op_class_q == rod_pkg::ROD_OP_ALU && op_func_q == 8'h01 && !is_compare_q)
        else $error("add with carry misdecoded");
    a_fp_unord: assert property (@(posedge ref_clk) disable iff (!rst_b)
        instr_valid && opc == 6'h32 && fp_fn >= 8'h28 && fp_fn <= 8'h2e
            |=> is_compare_q && op_class_q == rod_pkg::ROD_OP_FP_CMP && op_func_q == $past(fp_fn))
        else $error("unordered float compare misdecoded");
    a_fp_cust: assert property (@(posedge ref_clk) disable iff (!rst_b)
        instr_valid && opc == 6'h32 && (fp_fn[7:4] == 4'hd || fp_fn[7:4] == 4'he)
            |=> illegal_q && !is_compare_q)
        else $error("float custom slot not flagged");
    a_illegal_cust: assert property (@(posedge ref_clk) disable iff (!rst_b)
        instr_valid && opc >= 6'h3c |=> illegal_q && op_class_q == rod_pkg::ROD_OP_CUSTOM)
        else $error("custom opcode not flagged");
    a_valid_follow: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $past(rst_b) |-> dec_valid_q == $past(instr_valid) && (!illegal_q || dec_valid_q))
        else $error("decode valid out of step");
endmodule // rod_decoder

// ==== test/rod_fetch_model.sv ====
// fetch stage model that hands instruction words to the decoder
`timescale 1ns/100ps
module rod_fetch_model (
    input wire logic ref_clk,
    output logic instr_valid,
    output logic [31:0] instr
);
    initial begin
        instr_valid = 1'h0;
        instr = 32'h0;
    end
    // a word changes just after a rising edge and stands until the next issue
    task automatic issue(input logic [31:0] w, input logic v);
        @(posedge ref_clk);
        instr <= w;
        instr_valid <= v;
    endtask
endmodule // rod_fetch_model

// ==== test/risc_opcode_decoder_upper_tb.sv ====
// self-checking bench for the upper opcode decoder
`timescale 1ns/100ps
module risc_opcode_decoder_upper_tb;
    logic ref_clk = 1'h0;
    logic rst_b = 1'h0;
    logic instr_valid;
    logic [31:0] instr;
    logic dec_valid_q, is_compare_q, illegal_q;
    logic [4:0] d_idx_q, a_idx_q, b_idx_q;
    rod_pkg::rod_class_e op_class_q;
    logic [7:0] op_func_q;
    logic [15:0] store_imm_q;
    int bad_count = 0;
    int num_checks = 0;
    always #2 ref_clk = ~ref_clk;
    rod_fetch_model rod_fetch_model_i (
        .ref_clk(ref_clk), .instr_valid(instr_valid), .instr(instr));
    rod_decoder rod_decoder_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
        .dec_valid_q(dec_valid_q), .d_idx_q(d_idx_q), .a_idx_q(a_idx_q),
        .b_idx_q(b_idx_q), .op_class_q(op_class_q), .op_func_q(op_func_q),
        .is_compare_q(is_compare_q), .illegal_q(illegal_q), .store_imm_q(store_imm_q));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one word through the decoder, judged 1 ns after its sampling edge
    task automatic dec(input logic [31:0] w, input logic v, input rod_pkg::rod_class_e cls,
                       input logic [7:0] fn, input logic cmp, input logic ill, input bit skip);
        rod_fetch_model_i.issue(w, v);
        @(posedge ref_clk);
        #1;
        chk("valid", 32'(v), 32'(dec_valid_q));
        chk("compare", 32'(cmp), 32'(is_compare_q));
        chk("illegal", 32'(ill), 32'(illegal_q));
        chk("fields", 32'(w[25:11]), 32'({d_idx_q, a_idx_q, b_idx_q}));
        if (!skip) begin
            chk("class", 32'(cls), 32'(op_class_q));
            chk("func", 32'(fn), 32'(op_func_q));
        end
    endtask
    task automatic t_int_cmp();
        logic [4:0] subs [7] = '{5'h01, 5'h04, 5'h0c, 5'h05, 5'h0d, 5'h02, 5'h0a};
        for (int i = 0; i < 7; i++) begin
            dec({6'h39, subs[i], 5'(i + 3), 5'(i + 9), 11'h0}, 1'h1, rod_pkg::ROD_OP_INT_CMP,
                {3'h0, subs[i]}, 1'h1, 1'h0, 1'b0);
        end
    endtask
    task automatic t_ext();
        logic [7:0] codes [5] = '{8'h0d, 8'h1d, 8'h1c, 8'h3c, 8'h0c};
        for (int i = 0; i < 5; i++) begin
            dec({6'h38, 5'(i + 1), 5'(i + 20), 8'h0, codes[i]}, 1'h1, rod_pkg::ROD_OP_EXT,
                codes[i], 1'h0, 1'h0, 1'b0);
        end
    endtask
    task automatic t_addc();
        dec({6'h38, 5'h1f, 5'h00, 5'h11, 11'h001}, 1'h1, rod_pkg::ROD_OP_ALU,
            8'h01, 1'h0, 1'h0, 1'b0);
    endtask
    task automatic t_fp_cmp();
        for (int i = 8'h28; i <= 8'h2e; i++) begin
            dec({6'h32, 5'(i), 5'h1e, 5'h01, 3'h0, 8'(i)}, 1'h1, rod_pkg::ROD_OP_FP_CMP,
                8'(i), 1'h1, 1'h0, 1'b0);
        end
    endtask
    task automatic t_custom();
        dec({6'h32, 5'h02, 5'h03, 5'h04, 3'h0, 8'hd0}, 1'h1,
            rod_pkg::ROD_OP_FP_SINGLE_CUSTOM_SLOT, 8'hd0, 1'h0, 1'h1, 1'b0);
        dec({6'h32, 5'h05, 5'h06, 5'h07, 3'h0, 8'he0}, 1'h1,
            rod_pkg::ROD_OP_FP_DOUBLE_CUSTOM_SLOT, 8'he0, 1'h0, 1'h1, 1'b0);
        dec({6'h3c, 26'h2aaaaaa}, 1'h1, rod_pkg::ROD_OP_CUSTOM,
            8'h3c, 1'h0, 1'h1, 1'b0);
    endtask
    task automatic t_store();
        dec({6'h35, 5'h15, 5'h03, 5'h04, 11'h5a5}, 1'h1, rod_pkg::ROD_OP_STORE,
            8'h35, 1'h0, 1'h0, 1'b0);
        chk("store offset", 32'h0000ada5, 32'(store_imm_q));
    endtask
    task automatic t_other();
        dec({6'h32, 5'h01, 5'h02, 5'h03, 3'h0, 8'h00}, 1'h1, rod_pkg::ROD_OP_FP_ARITH,
            8'h00, 1'h0, 1'h0, 1'b0);
        dec({6'h32, 5'h04, 5'h05, 5'h06, 3'h0, 8'h34}, 1'h1, rod_pkg::ROD_OP_FP_CONV,
            8'h34, 1'h0, 1'h0, 1'b0);
        dec({6'h32, 5'h07, 5'h08, 5'h09, 3'h0, 8'h3e}, 1'h1, rod_pkg::ROD_OP_FP_CMP,
            8'h3e, 1'h1, 1'h0, 1'b0);
        dec({6'h38, 5'h0a, 5'h0b, 5'h0c, 3'h0, 8'hc8}, 1'h1, rod_pkg::ROD_OP_SHIFT,
            8'h38, 1'h0, 1'h0, 1'b0);
        dec({6'h38, 5'h0d, 5'h0e, 5'h0f, 1'h0, 10'h306}, 1'h1, rod_pkg::ROD_OP_MULDIV,
            8'h06, 1'h0, 1'h0, 1'b0);
        dec({6'h38, 5'h10, 5'h11, 5'h00, 1'h0, 10'h10f}, 1'h1, rod_pkg::ROD_OP_ALU,
            8'h1f, 1'h0, 1'h0, 1'b0);
    endtask
    task automatic t_bad();
        dec({6'h39, 5'h06, 5'h01, 5'h02, 11'h0}, 1'h1, rod_pkg::ROD_OP_NONE,
            8'h0, 1'h0, 1'h1, 1'b1);
        dec({6'h32, 5'h01, 5'h02, 5'h03, 3'h0, 8'h2f}, 1'h1, rod_pkg::ROD_OP_NONE,
            8'h0, 1'h0, 1'h1, 1'b1);
        dec({6'h39, 5'h01, 5'h0a, 5'h15, 11'h0}, 1'h0, rod_pkg::ROD_OP_INT_CMP,
            8'h01, 1'h0, 1'h0, 1'b0);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        results();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'h1;
        #1;
        chk("reset valid", 32'h0, 32'(dec_valid_q));
        chk("reset class", 32'(rod_pkg::ROD_OP_NONE), 32'(op_class_q));
        t_int_cmp();
        t_ext();
        t_addc();
        t_fp_cmp();
        t_custom();
        t_store();
        t_other();
        t_bad();
        results();
    end
endmodule // risc_opcode_decoder_upper_tb
